// [shared/sld_regs.vh]
// register map, field layout, level codes and divider taps of the scan driver
// assumes apb byte addresses are four times the register index
`ifndef SLD_REGS_VH
`define SLD_REGS_VH

// ------------------------------------------------------------------
// register indices (byte address = index * 4)
// ------------------------------------------------------------------
`define SLD_IDX_W 10
`define SLD_CTRL_IDX 10'h01B
`define SLD_STAT_IDX 10'h01C
`define SLD_RAM_BASE_IDX 10'h200
`define SLD_RAM_LAST_IDX 10'h22B
`define SLD_RAM_COL_BIT 2
`define SLD_RAM_ROW_LSB 3
`define SLD_RAM_WORDS 24

// ------------------------------------------------------------------
// display_control fields and reset value
// ------------------------------------------------------------------
`define SLD_CTRL_RST 8'h04
`define SLD_SEL_MSB 2
`define SLD_SEL_LSB 0
`define SLD_MODE_MSB 4
`define SLD_MODE_LSB 3
`define SLD_MODE_OFF 2'h0
`define SLD_MODE_RAM 2'h1
`define SLD_MODE_ALL0 2'h2
`define SLD_MODE_ALL1 2'h3

// ------------------------------------------------------------------
// scan clock select codes and slow divider masks (divisor - 1)
// ------------------------------------------------------------------
`define SLD_SEL_64 3'h0
`define SLD_SEL_128 3'h1
`define SLD_SEL_256 3'h4
`define SLD_SEL_512 3'h5
`define SLD_SEL_1K 3'h6
`define SLD_SEL_2K 3'h7
`define SLD_DIV_W 9
`define SLD_MASK_512 9'h1FF
`define SLD_MASK_256 9'h0FF
`define SLD_MASK_128 9'h07F
`define SLD_MASK_64 9'h03F
`define SLD_MASK_32 9'h01F
`define SLD_MASK_16 9'h00F

// ------------------------------------------------------------------
// drive level codes: ground, first bias, second bias, full supply
// ------------------------------------------------------------------
`define SLD_LVL_GND 2'h0
`define SLD_LVL_B1 2'h1
`define SLD_LVL_B2 2'h2
`define SLD_LVL_FULL 2'h3

`endif

// [hw/sld_scan_gen.v]
// slow clock binary divider and scan tick selection
// assumes slow_tick_i is a one-cycle pulse per slow clock period, already synchronised
`timescale 1ns/100ps
module sld_scan_gen (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire slow_tick_i,
  input wire [2:0] sel_i,
  output wire scan_tick_o
);
`include "sld_regs.vh"

  // ------------------------------------------------------------------
  // divider chain on the slow clock
  // ------------------------------------------------------------------
  reg [`SLD_DIV_W-1:0] slow_divider_tap;
  reg [`SLD_DIV_W-1:0] mask;

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slow_divider_tap <= {`SLD_DIV_W{1'b0}};
    end else if (slow_tick_i) begin
      slow_divider_tap <= slow_divider_tap + {{(`SLD_DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // unlisted codes fall back to the reset tap so the panel keeps a sane rate
  always @* begin
    case (sel_i)
      `SLD_SEL_64: mask = `SLD_MASK_512;
      `SLD_SEL_128: mask = `SLD_MASK_256;
      `SLD_SEL_256: mask = `SLD_MASK_128;
      `SLD_SEL_512: mask = `SLD_MASK_64;
      `SLD_SEL_1K: mask = `SLD_MASK_32;
      `SLD_SEL_2K: mask = `SLD_MASK_16;
      default: mask = `SLD_MASK_128;
    endcase
  end

  // one tick each time the selected tap completes a full period
  assign scan_tick_o = slow_tick_i && ((slow_divider_tap & mask) == mask);

endmodule

// [hw/sld_top.v]
// multiplexed segment lcd / led scan driver with apb register access
// assumes a free running 32 khz slow clock pin and an apb master on core_clk_i
`timescale 1ns/100ps
module sld_top #(
  parameter DUTY = 4,
  parameter BIAS_THIRD = 1,
  parameter SEG_COUNT = 32,
  parameter LED_MODE = 0
) (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire slow_clk_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  output reg [11:0] com_level_o,
  output reg [63:0] seg_level_o,
  output reg frame_start_o
);
`include "sld_regs.vh"

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function ram_hit;
    input [`SLD_IDX_W-1:0] idx;
    begin
      ram_hit = (idx >= `SLD_RAM_BASE_IDX) && (idx <= `SLD_RAM_LAST_IDX) &&
        !idx[`SLD_RAM_COL_BIT];
    end
  endfunction

  // row = common number, column = byte of the 32 segments
  function [4:0] ram_slot;
    input [`SLD_IDX_W-1:0] idx;
    reg [`SLD_IDX_W-1:0] off;
    begin
      off = idx - `SLD_RAM_BASE_IDX;
      ram_slot = {off[`SLD_RAM_ROW_LSB+2:`SLD_RAM_ROW_LSB], off[1:0]};
    end
  endfunction

  // lcd level of a common, alternating polarity each frame to keep dc off the glass
  function [1:0] com_lvl;
    input act;
    input pol;
    begin
      if (LED_MODE != 0) begin
        com_lvl = ((LED_MODE == 1) ~^ act) ? `SLD_LVL_FULL : `SLD_LVL_GND;
      end else if (act) begin
        com_lvl = pol ? `SLD_LVL_GND : `SLD_LVL_FULL;
      end else if (BIAS_THIRD != 0) begin
        com_lvl = pol ? `SLD_LVL_B2 : `SLD_LVL_B1;
      end else begin
        com_lvl = `SLD_LVL_B1;
      end
    end
  endfunction

  function [1:0] seg_lvl;
    input on;
    input pol;
    begin
      if (LED_MODE != 0) begin
        seg_lvl = ((LED_MODE == 1) ~^ on) ? `SLD_LVL_FULL : `SLD_LVL_GND;
      end else if (on) begin
        seg_lvl = pol ? `SLD_LVL_FULL : `SLD_LVL_GND;
      end else if (BIAS_THIRD != 0) begin
        seg_lvl = pol ? `SLD_LVL_B1 : `SLD_LVL_B2;
      end else begin
        seg_lvl = `SLD_LVL_B1;
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // slow clock synchroniser and tick
  // ------------------------------------------------------------------
  reg slow_s1;
  reg slow_s2;
  reg slow_s3;
  wire slow_tick;
  wire scan_tick;

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slow_s1 <= 1'b0;
      slow_s2 <= 1'b0;
      slow_s3 <= 1'b0;
    end else begin
      slow_s1 <= slow_clk_i;
      slow_s2 <= slow_s1;
      slow_s3 <= slow_s2;
    end
  end

  assign slow_tick = slow_s2 && !slow_s3;

  // ------------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------------
  reg [7:0] display_control;
  reg [7:0] display_ram [0:`SLD_RAM_WORDS-1];
  reg [2:0] com_idx;
  reg polarity;
  wire [`SLD_IDX_W-1:0] idx;
  wire mapped;
  wire wr_en;
  wire [1:0] mode;
  integer i;

  assign idx = paddr_i[11:2];
  assign mapped = (idx == `SLD_CTRL_IDX) || (idx == `SLD_STAT_IDX) || ram_hit(idx);
  // zero wait states: read data is captured in the setup cycle
  assign pready_o = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign wr_en = psel_i && penable_i && pwrite_i && mapped && pstrb_i[0];
  assign mode = display_control[`SLD_MODE_MSB:`SLD_MODE_LSB];

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      display_control <= `SLD_CTRL_RST;
    end else if (wr_en && (idx == `SLD_CTRL_IDX)) begin
      display_control <= {3'h0, pwdata_i[`SLD_MODE_MSB:0]};
    end
  end

  // ram written at any time; no reset needed beyond clearing for a known start
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (i = 0; i < `SLD_RAM_WORDS; i = i + 1) begin
        display_ram[i] <= 8'h00;
      end
    end else if (wr_en && ram_hit(idx)) begin
      display_ram[ram_slot(idx)] <= pwdata_i[7:0];
    end
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      if (idx == `SLD_CTRL_IDX) begin
        prdata_o <= {24'h000000, display_control};
      end else if (idx == `SLD_STAT_IDX) begin
        prdata_o <= {28'h0000000, polarity, com_idx};
      end else if (ram_hit(idx)) begin
        prdata_o <= {24'h000000, display_ram[ram_slot(idx)]};
      end else begin
        prdata_o <= 32'h00000000;
      end
    end
  end

  // ------------------------------------------------------------------
  // scan clock and common sequencer
  // ------------------------------------------------------------------
  sld_scan_gen u_scan_gen (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .slow_tick_i(slow_tick),
    .sel_i(display_control[`SLD_SEL_MSB:`SLD_SEL_LSB]),
    .scan_tick_o(scan_tick)
  );

  reg [31:0] row;
  wire [4:0] row_base;
  wire last_com;

  assign last_com = (com_idx == DUTY[2:0] - 3'h1);
  assign row_base = {com_idx, 2'h0};

  // the off mode parks the sequencer at common zero
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      com_idx <= 3'h0;
      polarity <= 1'b0;
      row <= 32'h00000000;
      frame_start_o <= 1'b0;
    end else begin
      frame_start_o <= 1'b0;
      if (mode == `SLD_MODE_OFF) begin
        com_idx <= 3'h0;
        polarity <= 1'b0;
      end else if (scan_tick) begin
        // row latched at each step, so ram changes appear from the next step
        row <= {display_ram[row_base + 5'h3], display_ram[row_base + 5'h2],
          display_ram[row_base + 5'h1], display_ram[row_base]};
        if (last_com) begin
          com_idx <= 3'h0;
          polarity <= !polarity;
          frame_start_o <= 1'b1;
        end else begin
          com_idx <= com_idx + 3'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // drive level generation
  // ------------------------------------------------------------------
  reg [2:0] drv_com;
  reg drv_valid;
  wire [11:0] next_com_level;
  wire [63:0] next_seg_level;

  // the common being driven follows the row latched with it
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drv_com <= 3'h0;
      drv_valid <= 1'b0;
    end else if (mode == `SLD_MODE_OFF) begin
      drv_valid <= 1'b0;
    end else if (scan_tick) begin
      drv_com <= com_idx;
      drv_valid <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_com
      wire used = (g < DUTY);
      assign next_com_level[2*g+1:2*g] = (used && drv_valid) ?
        com_lvl(drv_com == g, polarity) : `SLD_LVL_GND;
    end
    for (g = 0; g < 32; g = g + 1) begin : g_seg
      wire used = (g < SEG_COUNT);
      wire on = (mode == `SLD_MODE_ALL1) ? 1'b1 :
        (mode == `SLD_MODE_ALL0) ? 1'b0 : row[g];
      assign next_seg_level[2*g+1:2*g] = (used && drv_valid) ?
        seg_lvl(on, polarity) : `SLD_LVL_GND;
    end
  endgenerate

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      com_level_o <= 12'h000;
      seg_level_o <= 64'h0000000000000000;
    end else begin
      com_level_o <= next_com_level;
      seg_level_o <= next_seg_level;
    end
  end

endmodule

// [tb/sld_checker.sv]
// port checker for the scan driver
// assumes the lcd build with third bias, bound onto every sld_top instance
`timescale 1ns/100ps
module sld_checker #(
  parameter DUTY = 4,
  parameter SEG_COUNT = 32
) (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire slow_clk_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire [11:0] com_level_o,
  input wire [63:0] seg_level_o,
  input wire frame_start_o
);
  // ----
  // helpers
  // ----
  // a selected common sits at ground or full, both bits of its code equal
  logic [2:0] ext_cnt;
  always_comb begin
    ext_cnt = 3'h0;
    for (int n = 0; n < DUTY; n++) begin
      ext_cnt = ext_cnt + {2'h0, com_level_o[2*n] ~^ com_level_o[2*n+1]};
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_rd(a);
    psel_i && !penable_i && !pwrite_i && a;
  endsequence
  // ----
  // properties
  // ----
  a_zero_wait: assert property (pready_o == (psel_i && penable_i))
    else $error("pready not in access");
  a_err_read_zero: assert property (s_rd(1'b1) ##1 pslverr_o |-> prdata_o == 32'h0)
    else $error("error read not zero");
  a_ctrl_upper_zero: assert property (s_rd(paddr_i == 12'h06C) ##1 penable_i |-> prdata_o[31:5] == 27'h0)
    else $error("control upper bits set");
  a_ctrl_no_err: assert property (psel_i && penable_i && paddr_i == 12'h06C |-> !pslverr_o)
    else $error("control access refused");
  a_frame_pulse: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame pulse too long");
  a_com_unused: assert property ((com_level_o >> (2*DUTY)) == 12'h0)
    else $error("unused common driven");
  a_seg_unused: assert property ((seg_level_o >> (2*SEG_COUNT)) == 64'h0)
    else $error("unused segment driven");
  a_one_active: assert property (com_level_o != 12'h0 |-> ext_cnt == 3'h1)
    else $error("not one selected common");
endmodule

bind sld_top sld_checker #(.DUTY(DUTY), .SEG_COUNT(SEG_COUNT)) i_sld_checker (
  .core_clk_i, .arst_n_i, .slow_clk_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .com_level_o, .seg_level_o,
  .frame_start_o);

// [tb/sld_panel_model.sv]
// passive panel: decodes the selected common and the lit segments
// assumes lcd drive levels with third bias
`timescale 1ns/100ps
module sld_panel_model (
  input wire [11:0] com_level_i,
  input wire [63:0] seg_level_i,
  output logic [2:0] act_com_o,
  output logic [31:0] lit_o
);
  // lowest common at ground or full wins; unused commons idle at ground too
  always_comb begin
    act_com_o = 3'h7;
    for (int n = 5; n >= 0; n--) begin
      if (com_level_i[2*n] == com_level_i[2*n+1]) act_com_o = 3'(n);
    end
    for (int n = 0; n < 32; n++) begin
      lit_o[n] = seg_level_i[2*n] == seg_level_i[2*n+1];
    end
  end
endmodule

// [tb/tb_top.sv]
// bench for the scan driver: apb access, scan order, rates, modes
// assumes a slow clock four core cycles long, its edges falling on core clock falling edges
`timescale 1ns/100ps
`include "sld_regs.vh"
module tb_top;
  localparam int DUTY = 4;
  localparam int SEGS = 24;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic slow_clk = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h1;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire frame_start;
  wire [11:0] com_level;
  wire [63:0] seg_level;
  wire [2:0] act;
  wire [31:0] lit;
  logic [23:0] row [4];
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int samples_checked = 0;
  int fs_cnt = 0;
  int fs_base = 0;
  int gap;
  always #20 core_clk = ~core_clk;
  always #80 slow_clk = ~slow_clk;
  always @(posedge core_clk) if (frame_start === 1'b1) fs_cnt <= fs_cnt + 1;
  sld_top #(.DUTY(DUTY), .BIAS_THIRD(1), .SEG_COUNT(SEGS), .LED_MODE(0)) i_sld_top (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .slow_clk_i(slow_clk), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .com_level_o(com_level), .seg_level_o(seg_level), .frame_start_o(frame_start));
  sld_panel_model i_sld_panel_model (.com_level_i(com_level), .seg_level_i(seg_level),
    .act_com_o(act), .lit_o(lit));
  // ----
  // tasks
  // ----
  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits for the next scan step, then lets the levels settle three cycles
  task step();
    logic [11:0] c;
    c = com_level;
    gap = 0;
    do begin
      @(posedge core_clk);
      gap++;
    end while (com_level === c && gap < 5000);
    repeat (3) @(posedge core_clk);
  endtask
  function automatic int scan_cycles(input logic [2:0] sel);
    if (sel < 3'h2) return (512 >> sel) * 4;
    // unlisted codes run at the reset tap
    if (sel < 3'h4) return 128 * 4;
    return (128 >> (sel - 3'h4)) * 4;
  endfunction
  // ----
  // tests
  // ----
  initial begin
    #(40 * 80000);
    bad_count++;
    conclude();
  end
  initial begin
    void'($urandom(26976));
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, 12'h06C, 32'h0);
    chk("control reset", 32'h04, rd);
    pstrb <= 4'hE;
    apb(1'b1, 12'h06C, 32'h0000001F);
    pstrb <= 4'h1;
    apb(1'b0, 12'h06C, 32'h0);
    chk("masked write", 32'h04, rd);
    apb(1'b0, 12'h810, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    for (int c = 0; c < DUTY; c++) begin
      for (int k = 0; k < 3; k++) begin
        row[c][8*k +: 8] = 8'($urandom);
        apb(1'b1, 12'h800 + 12'(32 * c + 4 * k), {24'h0, row[c][8*k +: 8]});
      end
    end
    apb(1'b0, 12'h844, 32'h0);
    chk("ram read", {24'h0, row[2][15:8]}, rd);
    apb(1'b1, 12'h06C, {27'h0, `SLD_MODE_RAM, 3'h7});
    step();
    fs_base = fs_cnt;
    for (int s = 0; s < 2 * DUTY; s++) begin
      int p;
      p = act;
      step();
      chk("common order", 32'((p + 1) % DUTY), {29'h0, act});
      chk("segments", {8'h0, row[act]}, {8'h0, lit[23:0]});
      // the sequencer already points at the common that the next step shows
      apb(1'b0, 12'h070, 32'h0);
      chk("status common", 32'((act + 1) % DUTY), {29'h0, rd[2:0]});
    end
    chk("frames", 32'h2, 32'(fs_cnt - fs_base));
    row[0][7:0] = ~row[0][7:0];
    apb(1'b1, 12'h800, {24'h0, row[0][7:0]});
    repeat (2 * DUTY) step();
    while (act !== 3'h0) step();
    chk("ram update", {8'h0, row[0]}, {8'h0, lit[23:0]});
    for (int m = 2; m < 4; m++) begin
      apb(1'b1, 12'h06C, 32'(m * 8 + 7));
      step();
      chk("forced segs", m == 3 ? 32'hFFFFFF : 32'h0, {8'h0, lit[23:0]});
    end
    for (int i = 0; i < 8; i++) begin
      logic [2:0] s;
      s = 3'(i);
      apb(1'b1, 12'h06C, {27'h0, `SLD_MODE_RAM, s});
      step();
      step();
      chk("scan period", 32'(scan_cycles(s)), 32'(gap + 3));
    end
    apb(1'b1, 12'h06C, {27'h0, `SLD_MODE_OFF, 3'h7});
    repeat (4) @(posedge core_clk);
    chk("off levels", 32'h0, {31'h0, |{com_level, seg_level}});
    apb(1'b0, 12'h070, 32'h0);
    chk("status off", 32'h0, rd);
    conclude();
  end
endmodule
